//--- common/tve_pkg.sv
// Constants shared by the timestamp and value encoding block.
// Assumes a 200 MHz aclk and a word-indexed register window on AXI4-Lite.
package tve_pkg;

    // ************************************************************
    // Clock and timing.
    // ************************************************************
    // Core clock rate in MHz.
    localparam int CLK_MHZ = 200;
    // Length of one timer tick, in milliseconds.
    localparam int TICK_MS = 1;
    // Clock cycles in one timer tick.
    localparam int TICK_CYCLES = CLK_MHZ * 1000 * TICK_MS;
    // Window after an external synchronisation, in hours.
    localparam int SYNC_WINDOW_H = 2;
    // The same window counted in ticks.
    localparam int WINDOW_TICKS = (SYNC_WINDOW_H * 3600 * 1000) / TICK_MS;

    // ************************************************************
    // Register indices (byte address is four times the index).
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] IDX_FLAG_QUAL = 5'h00;
    localparam logic [IDX_W-1:0] IDX_FLAGS = 5'h01;
    localparam logic [IDX_W-1:0] IDX_NAT_TS = 5'h02;
    localparam logic [IDX_W-1:0] IDX_NAT_LAST = 5'h05;
    localparam logic [IDX_W-1:0] IDX_STD_TS = 5'h06;
    localparam logic [IDX_W-1:0] IDX_STD_LAST = 5'h09;
    localparam logic [IDX_W-1:0] IDX_TS_QUAL = 5'h0A;
    localparam logic [IDX_W-1:0] IDX_ENERGY = 5'h0B;
    localparam logic [IDX_W-1:0] IDX_ENERGY_LAST = 5'h0E;
    localparam logic [IDX_W-1:0] IDX_REAL = 5'h0F;
    localparam logic [IDX_W-1:0] IDX_REAL_LAST = 5'h10;
    localparam logic [IDX_W-1:0] IDX_NEUTRAL = 5'h11;
    localparam logic [IDX_W-1:0] IDX_UWORD = 5'h12;
    localparam logic [IDX_W-1:0] IDX_CTRL = 5'h13;

    // ************************************************************
    // Fields, reset values and special patterns.
    // ************************************************************
    localparam int TSQ_EXT_BIT = 12;
    localparam int TSQ_SYNC_BIT = 13;
    localparam int TSQ_SET_BIT = 14;
    localparam int CTRL_NEUTRAL_NA_BIT = 0;
    localparam int CTRL_OOO_BIT = 1;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_MASK = 16'h0003;
    localparam logic [15:0] NA_U16 = 16'hFFFF;
    localparam logic [15:0] NA_S16 = 16'h8000;
    localparam logic [15:0] NEUTRAL_NA = 16'h8000;
    localparam logic [63:0] NA_S64 = 64'h8000_0000_0000_0000;
    localparam logic [31:0] NA_REAL = 32'hFFC0_0000;
    // Year bases 1900 and 2000 and the coded limits.
    localparam logic [11:0] YEAR_NAT_BASE = 12'h076C;
    localparam logic [11:0] YEAR_STD_BASE = 12'h07D0;
    localparam logic [11:0] YEAR_NAT_MIN = 12'h0050;
    localparam logic [11:0] YEAR_NAT_MAX = 12'h00C7;
    localparam logic [11:0] YEAR_STD_MAX = 12'h007F;
    localparam logic [15:0] MS_PER_S = 16'h03E8;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // Synchronisation window states, one-hot.
    typedef enum logic [1:0] {
        SYNC_NONE = 2'b01,
        SYNC_INWIN = 2'b10
    } tve_sync_st_t;

endpackage

//--- common/tve_ts_if.sv
// Carries the time of day into the timestamp encoder and the coded words back.
// Assumes both ends sit on the same clock; the encoder is purely combinational.
`timescale 1ns/100ps
interface tve_ts_if;
    // Time of day in plain binary.
    logic [4:0] day;
    logic [3:0] month;
    logic [11:0] year;
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
    logic [9:0] millis;
    // Coded words, word 1 first.
    logic [15:0] nat_w [4];
    logic [15:0] std_w [4];
    // The owner of the time fields.
    modport src (output day, month, year, hours, minutes, seconds, millis,
                 input nat_w, std_w);
    // The encoder.
    modport enc (input day, month, year, hours, minutes, seconds, millis,
                 output nat_w, std_w);
endinterface

//--- testbench/test_tve_top.sv
// Self-checking bench: a table of reads in one loop, then hand-written cases.
// The master model carries the bus traffic; the monitor is bound below.
`timescale 1ns/100ps
module test_tve_top;
    logic aclk = 1'b0, aresetn = 1'b0, ext_sync_pulse = 1'b0, int_synced = 1'b0, date_set = 1'b1;
    logic energy_valid = 1'b1, real_valid = 1'b1, uword_valid = 1'b1;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hF, time_month = 4'hC;
    logic [4:0] time_day = 5'h1F, time_hours = 5'h17;
    logic [5:0] time_minutes = 6'h3B, time_seconds = 6'h3B;
    logic [9:0] time_millis = 10'h3E7;
    logic [11:0] time_year = 12'h07D0;
    logic [15:0] contact_flags = 16'hA5A5, contact_quality = 16'h0FF0, neutral_value = 16'h1234;
    logic [15:0] uword_value = 16'h0042;
    logic [31:0] real_value = 32'h3FC0_0000;
    logic [63:0] energy_value = 64'h0011_2233_4455_6677;
    wire [7:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ext_synced;
    int miscompares = 0, checked = 0;
    logic [33:0] v;
    logic [15:0] f;
    // Row: address, response, year in, word out.
    logic [47:0] rows [26] = '{48'h0800_07BC_0C1F, 48'h0C00_07BC_5017, 48'h0C00_07CF_6317,
        48'h0C00_07D0_6417, 48'h0C00_0833_C717, 48'h1000_07D0_3B3B, 48'h1400_07D0_03E7,
        48'h1800_07DD_000D, 48'h1800_084F_007F, 48'h1C00_07D0_0C1F, 48'h2000_07D0_173B,
        48'h2400_07D0_EA5F, 48'h0000_07D0_0FF0, 48'h0400_07D0_A5A5, 48'h2C00_07D0_0011,
        48'h3000_07D0_2233, 48'h3400_07D0_4455, 48'h3800_07D0_6677, 48'h3420_07D0_0000,
        48'h4400_07D0_1234, 48'h4800_07D0_0042, 48'h8030_07D0_0000, 48'h5030_07D0_0000,
        48'h1800_07CF_0000, 48'h0C00_07BB_5017, 48'h0C00_0834_C717};
    tve_top #(.TICK_CYCLES(4), .WINDOW_TICKS(10)) u_dut (.*);
    tve_master u_mst (.*);
    initial forever #2.5 aclk = ~aclk;
    task automatic chk(input logic [33:0] s, input logic [33:0] x);
        checked++;
        if (s !== x) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic give_verdict();
        miscompares += u_mst.hung;
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One bus access; a wait that ran out ends the run.
    task automatic op(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        u_mst.go(w, a, d, v);
        chk(v, {er, 16'h0000, w ? 16'h0000 : d});
        if (u_mst.hung) give_verdict();
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            time_year <= rows[i][27:16];
            op(1'b0, rows[i][47:40], rows[i][15:0], rows[i][37:36]);
        end
        u_mst.flags(f);
        chk({18'h0, f}, {18'h0, 16'h05A0});
        if (u_mst.hung) give_verdict();
        ext_sync_pulse <= 1'b1;
        @(posedge aclk);
        ext_sync_pulse <= 1'b0;
        op(1'b0, 8'h28, 16'h5000, 2'h0);
        // The window is forty cycles with the shortened timer.
        repeat (60) @(posedge aclk);
        int_synced <= 1'b1;
        uword_valid <= 1'b0;
        real_valid <= 1'b0;
        op(1'b0, 8'h28, 16'h6000, 2'h0);
        op(1'b0, 8'h48, 16'hFFFF, 2'h0);
        op(1'b0, 8'h3C, 16'hFFC0, 2'h0);
        op(1'b0, 8'h40, 16'h0000, 2'h0);
        op(1'b1, 8'h44, 16'h0001, 2'h2);
        op(1'b1, 8'h80, 16'h0001, 2'h3);
        op(1'b1, 8'h4C, 16'h0001, 2'h0);
        // A write with the low lane off leaves the control word alone.
        s_axi_wstrb <= 4'hE;
        op(1'b1, 8'h4C, 16'h0000, 2'h0);
        s_axi_wstrb <= 4'hF;
        op(1'b0, 8'h44, 16'h8000, 2'h0);
        op(1'b1, 8'h4C, 16'hFFFF, 2'h0);
        op(1'b0, 8'h4C, 16'h0003, 2'h0);
        op(1'b0, 8'h2C, 16'h8000, 2'h0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        op(1'b0, 8'h4C, 16'h0000, 2'h0);
        give_verdict();
    end
endmodule // test_tve_top
bind tve_top tve_top_monitor u_mon (.*);

//--- testbench/tve_master.sv
// Bus master standing in for the supervisory reader of the register window.
// Assumes the slave answers on aclk; hung marks a wait that ran out.
`timescale 1ns/100ps
module tve_master (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr = 8'h00,
    output logic s_axi_awvalid = 1'b0,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h0000_0000,
    output logic s_axi_wvalid = 1'b0,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    output logic [7:0] s_axi_araddr = 8'h00,
    output logic s_axi_arvalid = 1'b0,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
    logic hung = 1'b0;
    task automatic go(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [33:0] v);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {16'h0000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        // Each request is dropped only at the edge that takes it.
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid || s_axi_rvalid) break;
        end
        v = w ? {s_axi_bresp, 32'h0000_0000} : {s_axi_rresp, s_axi_rdata};
        {s_axi_bready, s_axi_rready} <= 2'b00;
        if (n == 64) hung = 1'b1;
    endtask
    // flags kept only where quality is one
    task automatic flags(output logic [15:0] f);
        logic [33:0] q, r;
        go(1'b0, 8'h00, 16'h0000, q);
        go(1'b0, 8'h04, 16'h0000, r);
        f = q[15:0] & r[15:0];
    endtask
endmodule // tve_master

//--- testbench/tve_top_monitor.sv
// Concurrent checks on the read channel and sync flag of the encoder top.
// Sees only top-level ports; the bench top file binds it in.
`timescale 1ns/100ps
module tve_top_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [tve_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_sync_pulse,
    input wire logic ext_synced
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Read address accepted at this edge.
    wire ar = s_axi_arvalid && s_axi_arready;
    property p_rlat; ar |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
    a_rdrop: assert property (p_rdrop) else $error("read answer not released");
    property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arblk: assert property (p_arblk) else $error("second read taken");
    property p_rhi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_rhi: assert property (p_rhi) else $error("upper half not zero");
    property p_tsq; ar && s_axi_araddr == 8'h28 |=> (s_axi_rdata & 32'hFFFF_8FFF) == 32'h0000_0000
        && s_axi_rdata[12] == $past(ext_synced); endproperty
    a_tsq: assert property (p_tsq) else $error("quality word wrong");
    property p_std4; ar && s_axi_araddr == 8'h24 |=> s_axi_rdata <= 32'h0000_EA5F; endproperty
    a_std4: assert property (p_std4) else $error("millisecond word too big");
    property p_dec; ar && s_axi_araddr[7] |=> s_axi_rresp == 2'h3; endproperty
    a_dec: assert property (p_dec) else $error("unmapped read not refused");
    property p_held; ext_sync_pulse |=> ext_synced [*8]; endproperty
    a_held: assert property (p_held) else $error("sync flag dropped early");
endmodule // tve_top_monitor

//--- verilog/tve_sync_timer.sv
// Tracks whether the last external synchronisation is recent enough.
// Assumes sync_pulse is a one-cycle pulse from logic on aclk.
`timescale 1ns/100ps
module tve_sync_timer #(
    parameter int TICK_CYCLES = tve_pkg::TICK_CYCLES,
    parameter int WINDOW_TICKS = tve_pkg::WINDOW_TICKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sync_pulse,
    output logic ext_synced
);

    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam int WW = $clog2(WINDOW_TICKS + 1);

    tve_pkg::tve_sync_st_t state_q; // Window state.
    logic [PW-1:0] presc_q; // Cycles within the current tick.
    logic [WW-1:0] ticks_q; // Ticks since the last sync.
    logic tick; // One-cycle tick enable.

    assign tick = (presc_q == PW'(TICK_CYCLES - 1));

    // ************************************************************
    // Tick divider.
    // ************************************************************
    // A sync restarts the divider so the window is never short by a tick.
    always_ff @(posedge aclk) begin
        if (!aresetn || sync_pulse || tick) begin
            presc_q <= '0;
        end else begin
            presc_q <= PW'(presc_q + 1'b1);
        end
    end

    // ************************************************************
    // Window state machine.
    // ************************************************************
    // two-hour sync window.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= tve_pkg::SYNC_NONE;
            ticks_q <= '0;
        end else if (sync_pulse) begin
            state_q <= tve_pkg::SYNC_INWIN;
            ticks_q <= '0;
        end else begin
            case (state_q)
                tve_pkg::SYNC_INWIN: begin
                    if (tick && ticks_q == WW'(WINDOW_TICKS - 1)) begin
                        state_q <= tve_pkg::SYNC_NONE;
                    end else if (tick) begin
                        ticks_q <= WW'(ticks_q + 1'b1);
                    end
                end
                default: begin
                    ticks_q <= '0;
                end
            endcase
        end
    end

    assign ext_synced = (state_q == tve_pkg::SYNC_INWIN);

endmodule // tve_sync_timer

//--- verilog/tve_top.sv
// Register window that presents timestamps and measured values as 16-bit words.
// Assumes an AXI4-Lite master on aclk and value inputs from logic on aclk.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module tve_top #(
    parameter int TICK_CYCLES = tve_pkg::TICK_CYCLES,
    parameter int WINDOW_TICKS = tve_pkg::WINDOW_TICKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [tve_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tve_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] time_day,
    input wire logic [3:0] time_month,
    input wire logic [11:0] time_year,
    input wire logic [4:0] time_hours,
    input wire logic [5:0] time_minutes,
    input wire logic [5:0] time_seconds,
    input wire logic [9:0] time_millis,
    input wire logic ext_sync_pulse,
    input wire logic int_synced,
    input wire logic date_set,
    input wire logic [15:0] contact_flags,
    input wire logic [15:0] contact_quality,
    input wire logic [63:0] energy_value,
    input wire logic energy_valid,
    input wire logic [31:0] real_value,
    input wire logic real_valid,
    input wire logic [15:0] neutral_value,
    input wire logic [15:0] uword_value,
    input wire logic uword_valid,
    output logic ext_synced
);

    // ************************************************************
    // Decoding helpers.
    // ************************************************************
    // True for any address inside the register window.
    function automatic logic is_mapped(input logic [tve_pkg::ADDR_W-1:0] a);
        return (a[tve_pkg::ADDR_W-1] == 1'b0) && (a[6:2] <= tve_pkg::IDX_CTRL);
    endfunction

    // True for the first word of a multi-word block.
    function automatic logic is_head(input logic [tve_pkg::IDX_W-1:0] i);
        return (i == tve_pkg::IDX_ENERGY) || (i == tve_pkg::IDX_REAL);
    endfunction

    // True for the last word of a multi-word block.
    function automatic logic is_last(input logic [tve_pkg::IDX_W-1:0] i);
        return (i == tve_pkg::IDX_ENERGY_LAST) || (i == tve_pkg::IDX_REAL_LAST);
    endfunction

    // ************************************************************
    // Submodules.
    // ************************************************************
    tve_ts_if ts (); // Time fields and coded timestamps.

    assign ts.day = time_day;
    assign ts.month = time_month;
    assign ts.year = time_year;
    assign ts.hours = time_hours;
    assign ts.minutes = time_minutes;
    assign ts.seconds = time_seconds;
    assign ts.millis = time_millis;

    tve_ts_encoder u_enc (
        .ts(ts)
    );

    tve_sync_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .WINDOW_TICKS(WINDOW_TICKS)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .sync_pulse(ext_sync_pulse),
        .ext_synced(ext_synced)
    );

    // ************************************************************
    // State.
    // ************************************************************
    logic [15:0] ctrl_q; // Neutral-absent and out-of-order controls.
    logic aw_have_q; // Write address held.
    logic [tve_pkg::ADDR_W-1:0] aw_addr_q; // Held write address.
    logic w_have_q; // Write data held.
    logic [15:0] w_data_q; // Held write data, low half.
    logic w_lane_q; // Low byte lane enabled.
    logic bvalid_q; // Write response pending.
    logic [1:0] bresp_q; // Write response code.
    logic rvalid_q; // Read response pending.
    logic [31:0] rdata_q; // Read data.
    logic [1:0] rresp_q; // Read response code.
    logic [63:0] snap_q; // Block snapshot, first word in the top bits.
    logic seq_act_q; // A block read is in progress.
    logic [tve_pkg::IDX_W-1:0] seq_next_q; // Index the block expects next.
    logic [1:0] seq_off_q; // Word offset of that index in the block.

    // Read decode results.
    logic [tve_pkg::IDX_W-1:0] ridx; // Read word index.
    logic [15:0] rd_word;
    logic [1:0] rd_resp;
    logic snap_load;
    logic [63:0] snap_val;
    logic seq_act_d;
    logic [tve_pkg::IDX_W-1:0] seq_next_d;
    logic [1:0] seq_off_d;
    logic [15:0] ts_qual; // Timestamp quality word.
    logic ooo; // Software forces values out of order.
    logic ar_hs; // Read address taken.
    logic wr_go; // Both write halves held.

    assign ridx = s_axi_araddr[6:2];
    assign ooo = ctrl_q[tve_pkg::CTRL_OOO_BIT];
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign wr_go = aw_have_q && w_have_q && !bvalid_q;

    // Only bits 12 to 14 carry meaning; the rest are built as zero.
    always_comb begin
        ts_qual = '0;
        ts_qual[tve_pkg::TSQ_EXT_BIT] = ext_synced;
        ts_qual[tve_pkg::TSQ_SYNC_BIT] = int_synced;
        ts_qual[tve_pkg::TSQ_SET_BIT] = date_set;
    end

    // ************************************************************
    // Read decode.
    // ************************************************************
    // Blocks are snapshot on their first word so a multi-word value
    // cannot tear between reads; the price is that a block must be read
    // in order, first word first.
    always_comb begin
        rd_word = '0;
        rd_resp = tve_pkg::RESP_OKAY;
        snap_load = 1'b0;
        snap_val = '0;
        seq_act_d = 1'b0;
        seq_next_d = seq_next_q;
        seq_off_d = seq_off_q;
        if (!is_mapped(s_axi_araddr)) begin
            rd_resp = tve_pkg::RESP_DECERR;
        end else if (ridx == tve_pkg::IDX_FLAG_QUAL) begin
            rd_word = contact_quality;
        end else if (ridx == tve_pkg::IDX_FLAGS) begin
            rd_word = contact_flags;
        end else if (ridx <= tve_pkg::IDX_NAT_LAST) begin
            rd_word = ts.nat_w[2'(ridx - tve_pkg::IDX_NAT_TS)];
        end else if (ridx <= tve_pkg::IDX_STD_LAST) begin
            rd_word = ts.std_w[2'(ridx - tve_pkg::IDX_STD_TS)];
        end else if (ridx == tve_pkg::IDX_TS_QUAL) begin
            rd_word = ts_qual;
        end else if (is_head(ridx)) begin
            if (ridx == tve_pkg::IDX_ENERGY) begin
                snap_val = (energy_valid && !ooo) ? energy_value : tve_pkg::NA_S64;
            end else begin
                snap_val = {((real_valid && !ooo) ? real_value : tve_pkg::NA_REAL), 32'h0000_0000};
            end
            snap_load = 1'b1;
            rd_word = snap_val[63:48];
            seq_act_d = 1'b1;
            seq_next_d = tve_pkg::IDX_W'(ridx + 1'b1);
            seq_off_d = 2'd1;
        end else if (ridx <= tve_pkg::IDX_REAL_LAST) begin
            if (seq_act_q && ridx == seq_next_q) begin
                rd_word = snap_q[6'(63 - 16 * seq_off_q) -: 16];
                seq_act_d = !is_last(ridx);
                seq_next_d = tve_pkg::IDX_W'(ridx + 1'b1);
                seq_off_d = 2'(seq_off_q + 1'b1);
            end else begin
                rd_resp = tve_pkg::RESP_SLVERR;
            end
        end else if (ridx == tve_pkg::IDX_NEUTRAL) begin
            if (ctrl_q[tve_pkg::CTRL_NEUTRAL_NA_BIT]) begin
                rd_word = tve_pkg::NEUTRAL_NA;
            end else if (ooo) begin
                rd_word = tve_pkg::NA_S16;
            end else begin
                rd_word = neutral_value;
            end
        end else if (ridx == tve_pkg::IDX_UWORD) begin
            rd_word = (uword_valid && !ooo) ? uword_value : tve_pkg::NA_U16;
        end else begin
            rd_word = ctrl_q;
        end
    end

    // ************************************************************
    // Read channel.
    // ************************************************************
    // One read at a time: the address is refused while data is pending.
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= tve_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_word};
            rresp_q <= rd_resp;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Any read that is not the expected next block word ends the block.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_act_q <= 1'b0;
            seq_next_q <= '0;
            seq_off_q <= '0;
            snap_q <= '0;
        end else if (ar_hs) begin
            seq_act_q <= seq_act_d;
            seq_next_q <= seq_next_d;
            seq_off_q <= seq_off_d;
            if (snap_load) begin
                snap_q <= snap_val;
            end
        end
    end

    // ************************************************************
    // Write channel.
    // ************************************************************
    // Address and data are taken in either order and held until both
    // have arrived; each ready drops while its half is held.
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || wr_go) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || wr_go) begin
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_lane_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata[15:0];
            w_lane_q <= s_axi_wstrb[0];
        end
    end

    // Only the control word is writable; the rest answer with an error
    // so that a misdirected write is visible to software.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= tve_pkg::CTRL_RESET;
            bvalid_q <= 1'b0;
            bresp_q <= tve_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            if (!is_mapped(aw_addr_q)) begin
                bresp_q <= tve_pkg::RESP_DECERR;
            end else if (aw_addr_q[6:2] == tve_pkg::IDX_CTRL) begin
                bresp_q <= tve_pkg::RESP_OKAY;
                if (w_lane_q) begin
                    ctrl_q <= w_data_q & tve_pkg::CTRL_MASK;
                end
            end else begin
                bresp_q <= tve_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule // tve_top

//--- verilog/tve_ts_encoder.sv
// Encodes the time of day into the module-native and standard timestamps.
// Assumes its inputs are in range; years outside a format are clamped.
`timescale 1ns/100ps
module tve_ts_encoder (
    tve_ts_if.enc ts
);

    // ************************************************************
    // Year coding.
    // ************************************************************
    logic [11:0] nat_year; // Year minus 1900, clamped.
    logic [11:0] std_year; // Year minus 2000, clamped.

    // Clamping keeps a wild year from wrapping into a plausible one.
    always_comb begin
        if (ts.year < (tve_pkg::YEAR_NAT_BASE + tve_pkg::YEAR_NAT_MIN)) begin
            nat_year = tve_pkg::YEAR_NAT_MIN;
        end else if (ts.year > (tve_pkg::YEAR_NAT_BASE + tve_pkg::YEAR_NAT_MAX)) begin
            nat_year = tve_pkg::YEAR_NAT_MAX;
        end else begin
            nat_year = ts.year - tve_pkg::YEAR_NAT_BASE;
        end
        if (ts.year < tve_pkg::YEAR_STD_BASE) begin
            std_year = '0;
        end else if (ts.year > (tve_pkg::YEAR_STD_BASE + tve_pkg::YEAR_STD_MAX)) begin
            std_year = tve_pkg::YEAR_STD_MAX;
        end else begin
            std_year = ts.year - tve_pkg::YEAR_STD_BASE;
        end
    end

    // ************************************************************
    // Word packing.
    // ************************************************************
    // Reserved positions are built as zero, never left floating.
    always_comb begin
        ts.nat_w[0] = {4'h0, ts.month, 3'h0, ts.day};
        ts.nat_w[1] = {nat_year[7:0], 3'h0, ts.hours};
        ts.nat_w[2] = {2'h0, ts.minutes, 2'h0, ts.seconds};
        ts.nat_w[3] = {6'h00, ts.millis};
        ts.std_w[0] = {9'h000, std_year[6:0]};
        ts.std_w[1] = {4'h0, ts.month, 3'h0, ts.day};
        ts.std_w[2] = {3'h0, ts.hours, 2'h0, ts.minutes};
        ts.std_w[3] = 16'(16'(ts.seconds) * tve_pkg::MS_PER_S + 16'(ts.millis));
    end

endmodule // tve_ts_encoder
